//--- verilog/port_e_f_pin_control.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "pin_ports_map.svh"

// Notes on behaviour
// - a direction bit of 1 turns the pin driver off, pin is input
// - a direction bit of 0 drives the pin from its latch bit
// - second port has seven bidirectional pins, each with a direction bit
// - latch register readable; read-modify-write uses latch, not pin levels
// - each second port pin is individually input or output
// - pin 7 of second port has no analog function; pins 1 to 6 do
// - pins 1 to 6 serve comparators when comparator control selects it
// - pins 3 to 6 read no digital input while comparators are on
// - after reset pins 1 to 6 are analog inputs and read 0
// - pins 6 and 7 of first port carry memory bits 14, 15 while the memory bus is active
// - external memory use of a pin beats every other function
// - memory bits 14 and 15 exist only on the 80-pin part
// - pwm one channel b overrides pin 6 at direction 0, may tristate
// - pwm one channel b reaches first port only with remap bit set, 80-pin
// - capture unit two uses pin 7 only when remap clear, mcu mode
// - pin 7 gives compare output at direction 0, capture input at 1
// - pwm two channel a overrides pin 7 at direction 0, may tristate
// - pull-up enable j is absent on 64-pin parts and reads 0
// - bit 0 of second port registers is absent and reads 0
// - analog enabled pin: digital input off, digital output still works
module port_e_f_pin_control (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic                             pready,
    output logic [31:0]                      prdata,
    output logic                             pslverr,
    // configuration straps, asynchronous
    input  wire pin_ports_pkg::device_cfg_s  cfg_pins,
    // first port pins
    input  wire logic [7:0]                  first_port_in,
    output logic [7:0]                       first_port_out,
    output logic [7:0]                       first_port_oe,
    // second port pins
    input  wire logic [7:1]                  second_port_in,
    output logic [7:1]                       second_port_out,
    output logic [7:1]                       second_port_oe,
    // peripherals sharing the first port
    input  wire pin_ports_pkg::ext_mem_s     ext_mem,
    input  wire pin_ports_pkg::periph_drive_s pwm_one_channel_b,
    input  wire pin_ports_pkg::periph_drive_s pwm_two_channel_a,
    input  wire pin_ports_pkg::periph_drive_s capture_compare_two,
    output logic [1:0]                       ext_mem_in,
    output logic                             capture_two_in,
    // peripherals sharing the second port
    input  wire pin_ports_pkg::cmp_out_t     cmp_out,
    output logic                             slave_select_in,
    // pull-up enables
    output logic                             pullup_enable_d,
    output logic                             pullup_enable_e,
    output logic                             pullup_enable_j
);

    // software state
    logic [7:0]                  first_latch;
    logic [7:0]                  first_port_direction;
    logic [7:0]                  second_latch;
    logic [7:0]                  second_port_direction;
    logic [7:0]                  comparator_control;
    logic [7:0]                  converter_config;
    // pin and strap synchronisers
    logic [7:0]                  first_meta;
    logic [7:0]                  first_sync;
    logic [7:1]                  second_meta;
    logic [7:1]                  second_sync;
    pin_ports_pkg::device_cfg_s  cfg_meta;
    pin_ports_pkg::device_cfg_s  cfg;
    // decode and pin muxing
    logic                        wr_en;
    logic                        setup;
    logic                        mapped;
    logic [31:0]                 next_prdata;
    logic [7:0]                  first_pins;
    logic [7:0]                  second_pins;
    logic                        cmp_on;
    logic                        emi_on;
    logic                        p1b_on;
    logic                        ccp_route;
    logic                        p2a_on;
    logic                        ccp_on;
    logic [7:0]                  next_first_out;
    logic [7:0]                  next_first_oe;
    logic [7:1]                  next_second_out;
    logic [7:1]                  next_second_oe;

    // two flops on every asynchronous input; only the second is read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_meta  <= 8'h00;
            first_sync  <= 8'h00;
            second_meta <= 7'h00;
            second_sync <= 7'h00;
            cfg_meta    <= '0;
            cfg         <= '0;
        end else begin
            first_meta  <= first_port_in;
            first_sync  <= first_meta;
            second_meta <= second_port_in;
            second_sync <= second_meta;
            cfg_meta    <= cfg_pins;
            cfg         <= cfg_meta;
        end
    end

    // apb phases: one wait-free access cycle, pready raised by the slave
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // first port latch: latch and pins offsets both load it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_latch <= `RST_LATCH;
        end else if (wr_en && (paddr == `OFF_FIRST_LATCH ||
                               paddr == `OFF_FIRST_PINS)) begin
            first_latch <= pwdata[7:0];
        end
    end

    // first port direction, all inputs after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_port_direction <= `RST_DIR;
        end else if (wr_en && paddr == `OFF_FIRST_DIR) begin
            first_port_direction <= pwdata[7:0];
        end
    end

    // second port latch; bit 0 does not exist
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            second_latch <= `RST_LATCH;
        end else if (wr_en && (paddr == `OFF_SECOND_LATCH ||
                               paddr == `OFF_SECOND_PINS)) begin
            second_latch <= pwdata[7:0] & `SECOND_IMPL_MASK;
        end
    end

    // second port direction, seven separate bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            second_port_direction <= `RST_SECOND_DIR;
        end else if (wr_en && paddr == `OFF_SECOND_DIR) begin
            second_port_direction <= pwdata[7:0] & `SECOND_IMPL_MASK;
        end
    end

    // comparator control: mode in the low bits, output routing above
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            comparator_control <= `RST_CMP;
        end else if (wr_en && paddr == `OFF_CMP_CONTROL) begin
            comparator_control <= pwdata[7:0];
        end
    end

    // converter config: one analog enable per pin 1..6, pin 7 never analog
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            converter_config <= `RST_ANALOG;
        end else if (wr_en && paddr == `OFF_CONV_CONFIG) begin
            converter_config <= pwdata[7:0] & `ANALOG_MASK;
        end
    end

    // pull-up enables; the j bit cannot be set on the small package
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pullup_enable_d <= 1'b0;
            pullup_enable_e <= 1'b0;
            pullup_enable_j <= 1'b0;
        end else begin
            if (wr_en && paddr == `OFF_THIRD_PINS) begin
                pullup_enable_d <= pwdata[`PU_D_BIT];
                pullup_enable_e <= pwdata[`PU_E_BIT];
                pullup_enable_j <= pwdata[`PU_J_BIT] & cfg.package_80pin;
            end
            if (!cfg.package_80pin) begin
                pullup_enable_j <= 1'b0;
            end
        end
    end

    // digital read values: analog pins and comparator inputs read zero
    assign cmp_on = comparator_control[`CMP_MODE_MSB:0] != `CMP_MODE_OFF;
    assign first_pins = first_sync;
    always_comb begin
        second_pins = {second_sync, 1'b0};
        second_pins = second_pins & ~converter_config;
        if (cmp_on) begin
            second_pins = second_pins & ~`CMP_INPUT_MASK;
        end
    end

    // read mux, taken in the setup cycle and shown in the access cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        mapped      = 1'b1;
        unique case (paddr)
            `OFF_FIRST_PINS:   next_prdata[7:0] = first_pins;
            `OFF_FIRST_LATCH:  next_prdata[7:0] = first_latch;
            `OFF_FIRST_DIR:    next_prdata[7:0] = first_port_direction;
            `OFF_THIRD_PINS: begin
                next_prdata[`PU_D_BIT] = pullup_enable_d;
                next_prdata[`PU_E_BIT] = pullup_enable_e;
                next_prdata[`PU_J_BIT] = pullup_enable_j;
            end
            `OFF_SECOND_PINS:  next_prdata[7:0] = second_pins;
            `OFF_SECOND_LATCH: next_prdata[7:0] = second_latch;
            `OFF_SECOND_DIR:   next_prdata[7:0] = second_port_direction;
            `OFF_CMP_CONTROL:  next_prdata[7:0] = comparator_control;
            `OFF_CONV_CONFIG:  next_prdata[7:0] = converter_config;
            default:           mapped = 1'b0;
        endcase
    end

    // read data and error stand for the single access cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= !mapped;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // first port function selection, highest priority last
    assign emi_on    = ext_mem.active && cfg.package_80pin;
    assign p1b_on    = cfg.package_80pin && cfg.pwm_pin_remap_bit &&
                       pwm_one_channel_b.active &&
                       !first_port_direction[6];
    assign ccp_route = !cfg.capture_two_remap_bit && cfg.mcu_mode;
    assign ccp_on    = ccp_route && capture_compare_two.active &&
                       !first_port_direction[7];
    assign p2a_on    = ccp_route && pwm_two_channel_a.active &&
                       !first_port_direction[7];

    always_comb begin
        next_first_out = first_latch;
        next_first_oe  = ~first_port_direction;
        if (p1b_on) begin
            next_first_out[6] = pwm_one_channel_b.level;
            next_first_oe[6]  = !pwm_one_channel_b.tristate;
        end
        if (ccp_on) begin
            next_first_out[7] = capture_compare_two.level;
            next_first_oe[7]  = 1'b1;
        end
        if (p2a_on) begin
            next_first_out[7] = pwm_two_channel_a.level;
            next_first_oe[7]  = !pwm_two_channel_a.tristate;
        end
        // memory bus ignores direction bits and wins over all else
        if (emi_on) begin
            next_first_out[7:6] = ext_mem.level;
            next_first_oe[7:6]  = {2{ext_mem.drive}};
        end
    end

    // second port: comparator outputs on pins 1 and 2 at direction 0
    always_comb begin
        next_second_out = second_latch[7:1];
        next_second_oe  = ~second_port_direction[7:1];
        if (cmp_on && comparator_control[`CMP_OUT_EN_BIT]) begin
            if (!second_port_direction[1]) begin
                next_second_out[1] = cmp_out[1];
            end
            if (!second_port_direction[2]) begin
                next_second_out[2] = cmp_out[0];
            end
        end
    end

    // pins driven from flops so no glitch from the mux reaches the board
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_port_out  <= 8'h00;
            first_port_oe   <= 8'h00;
            second_port_out <= 7'h00;
            second_port_oe  <= 7'h00;
        end else begin
            first_port_out  <= next_first_out;
            first_port_oe   <= next_first_oe;
            second_port_out <= next_second_out;
            second_port_oe  <= next_second_oe;
        end
    end

    // peripheral inputs taken from the synchronised pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_mem_in      <= 2'h0;
            capture_two_in  <= 1'b0;
            slave_select_in <= 1'b0;
        end else begin
            ext_mem_in <= cfg.package_80pin ? first_sync[7:6] : 2'h0;
            capture_two_in  <= ccp_route && first_port_direction[7] &&
                               first_sync[7];
            slave_select_in <= second_sync[7];
        end
    end

    // a set direction bit on the second port always releases the pin
    chk_dir_input_release:
    assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> (second_port_oe & $past(second_port_direction[7:1])) == 7'h00)
    else $error("second port driving a pin set as input");

    // a cleared direction bit on pin 7 shows the latch one cycle later
    chk_dir_output_latch:
    assert property (@(posedge clock) disable iff (rst)
        !second_port_direction[7] |=>
            second_port_oe[7] && second_port_out[7] == $past(second_latch[7]))
    else $error("second port pin 7 not driven from latch");

    // latch read-back returns the latch, never the pins
    chk_latch_readback:
    assert property (@(posedge clock) disable iff (rst)
        setup && !pwrite && paddr == `OFF_SECOND_LATCH |=>
            pready && prdata[7:0] == $past(second_latch))
    else $error("latch read returned wrong value");

    // analog or comparator pins read back zero
    chk_analog_reads_zero:
    assert property (@(posedge clock) disable iff (rst)
        setup && !pwrite && paddr == `OFF_SECOND_PINS |=>
            (prdata[7:0] & $past(converter_config)) == 8'h00 &&
            (!$past(cmp_on) || (prdata[7:0] & `CMP_INPUT_MASK) == 8'h00))
    else $error("analog pin read as nonzero");

    // memory bus owns pins 6 and 7 for two cycles whatever the direction
    chk_emi_priority:
    assert property (@(posedge clock) disable iff (rst)
        emi_on ##1 emi_on |=> first_port_oe[7:6] == {2{$past(ext_mem.drive)}}
            ##0 $past(first_port_out[7:6]) == $past(ext_mem.level, 2))
    else $error("memory bus lost pins 6 and 7");

    // small package never hands pins to the memory bus
    chk_no_emi_small_part:
    assert property (@(posedge clock) disable iff (rst)
        !cfg.package_80pin && !$past(cfg.package_80pin) |=>
            ext_mem_in == 2'h0)
    else $error("memory bus input on small package");

    // pwm one b takes pin 6 when routed and no memory bus
    chk_pwm_b_override:
    assert property (@(posedge clock) disable iff (rst)
        p1b_on && !emi_on |=>
            first_port_out[6] == $past(pwm_one_channel_b.level) &&
            first_port_oe[6] == !$past(pwm_one_channel_b.tristate))
    else $error("pwm one b not on pin 6");

    // capture input only follows pin 7 when routed as input
    chk_capture_input:
    assert property (@(posedge clock) disable iff (rst)
        !(ccp_route && first_port_direction[7]) |=> !capture_two_in)
    else $error("capture input seen while not routed");

    // pull-up j stays clear on the small package
    chk_pullup_j_absent:
    assert property (@(posedge clock) disable iff (rst)
        !cfg.package_80pin |=> !pullup_enable_j)
    else $error("pull-up j set on small package");

    // bit 0 of the second port registers reads zero
    chk_bit0_absent:
    assert property (@(posedge clock) disable iff (rst)
        second_latch[0] == 1'b0 && second_port_direction[0] == 1'b0)
    else $error("second port bit 0 implemented");

    // main scenarios
    cov_emi_use:
    cover property (@(posedge clock) disable iff (rst) emi_on ##1 emi_on);
    cov_dir_write:
    cover property (@(posedge clock) disable iff (rst)
        wr_en && paddr == `OFF_SECOND_DIR);
    cov_pin_read:
    cover property (@(posedge clock) disable iff (rst)
        setup && !pwrite && paddr == `OFF_SECOND_PINS ##1 pready);
    cov_pwm_a:
    cover property (@(posedge clock) disable iff (rst) p2a_on && !emi_on);

endmodule // port_e_f_pin_control

//--- common/pin_ports_map.svh
`ifndef PIN_PORTS_MAP_SVH
`define PIN_PORTS_MAP_SVH

// register byte offsets on the apb
`define OFF_FIRST_PINS      8'h00
`define OFF_FIRST_LATCH     8'h04
`define OFF_FIRST_DIR       8'h08
`define OFF_THIRD_PINS      8'h0C
`define OFF_SECOND_PINS     8'h10
`define OFF_SECOND_LATCH    8'h14
`define OFF_SECOND_DIR      8'h18
`define OFF_CMP_CONTROL     8'h1C
`define OFF_CONV_CONFIG     8'h20

// reset values
`define RST_LATCH           8'h00
`define RST_DIR             8'hFF
`define RST_SECOND_DIR      8'hFE
`define RST_ANALOG          8'h7E
`define RST_CMP             8'h00
`define RST_PULLUP          3'h0

// field positions and masks
`define SECOND_IMPL_MASK    8'hFE
`define ANALOG_MASK         8'h7E
`define CMP_INPUT_MASK      8'h78
`define CMP_MODE_MSB        2
`define CMP_OUT_EN_BIT      3
`define CMP_MODE_OFF        3'h7
`define PU_D_BIT            7
`define PU_E_BIT            6
`define PU_J_BIT            5

`endif

//--- common/pin_ports_pkg.sv
package pin_ports_pkg;

    // a peripheral that may take over a pin while its direction bit is 0
    typedef struct packed {
        logic active;
        logic level;
        logic tristate;
    } periph_drive_s;

    // external memory bus bits 14 and 15
    typedef struct packed {
        logic       active;
        logic       drive;
        logic [1:0] level;
    } ext_mem_s;

    // configuration straps of the part
    typedef struct packed {
        logic package_80pin;
        logic pwm_pin_remap_bit;
        logic capture_two_remap_bit;
        logic mcu_mode;
    } device_cfg_s;

    // comparator outputs: bit 1 comparator two, bit 0 comparator one
    typedef logic [1:0] cmp_out_t;

endpackage

//--- bench/board_model.sv
`timescale 1ns/1ns

module board_model (
    // pins as driven by the device
    input  wire logic [7:0] first_port_out,
    input  wire logic [7:0] first_port_oe,
    input  wire logic [7:1] second_port_out,
    input  wire logic [7:1] second_port_oe,
    // levels the board puts on pins the device leaves undriven
    input  wire logic [7:0] first_level,
    input  wire logic [7:1] second_level,
    // resolved wire levels seen by the device
    output logic      [7:0] first_port_in,
    output logic      [7:1] second_port_in
);
    // a driving device wins over the weak board source on each pin
    assign first_port_in  = (first_port_oe & first_port_out)
                          | (~first_port_oe & first_level);
    assign second_port_in = (second_port_oe & second_port_out)
                          | (~second_port_oe & second_level);
endmodule // board_model

//--- bench/testbench.sv
`timescale 1ns/1ns
`include "pin_ports_map.svh"

module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, cap_in, ss_in, pu_d, pu_e, pu_j;
    logic [31:0] prdata;
    pin_ports_pkg::device_cfg_s cfg = 4'h5;
    pin_ports_pkg::ext_mem_s ext = 4'h0;
    pin_ports_pkg::periph_drive_s pwm_b = 3'h0, pwm_a = 3'h0, ccp = 3'h0;
    pin_ports_pkg::cmp_out_t cmp = 2'h0;
    logic [7:0] fp_in, fp_out, fp_oe, f_lvl = 8'h00;
    logic [7:1] sp_in, sp_out, sp_oe, s_lvl = 7'h55;
    logic [1:0] mem_in;
    int err_count = 0;
    int checks = 0;

    // free running clock, 100 ns period
    always #50 clock = ~clock;

    port_e_f_pin_control dut_u (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cfg_pins(cfg), .first_port_in(fp_in), .first_port_out(fp_out),
        .first_port_oe(fp_oe), .second_port_in(sp_in),
        .second_port_out(sp_out), .second_port_oe(sp_oe), .ext_mem(ext),
        .pwm_one_channel_b(pwm_b), .pwm_two_channel_a(pwm_a),
        .capture_compare_two(ccp), .ext_mem_in(mem_in),
        .capture_two_in(cap_in), .cmp_out(cmp), .slave_select_in(ss_in),
        .pullup_enable_d(pu_d), .pullup_enable_e(pu_e),
        .pullup_enable_j(pu_j));

    board_model board_u (.first_port_out(fp_out), .first_port_oe(fp_oe),
        .second_port_out(sp_out), .second_port_oe(sp_oe),
        .first_level(f_lvl), .second_level(s_lvl),
        .first_port_in(fp_in), .second_port_in(sp_in));

    task print_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task cmp_v(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
             output logic [7:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_count++;
            print_verdict();
        end
        // let one edge pass so the next call never reassigns psel at once
        @(posedge clock);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic e;
        apb(1'b0, a, 8'h00, q, e);
        cmp_v(q, exp);
    endtask

    // sync stages plus output register
    task settle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task check_reset();
        logic [7:0] q;
        logic e;
        cmp_v(fp_oe, 8'h00);
        cmp_v({sp_oe, 1'b0}, 8'h00);
        rdc(`OFF_FIRST_DIR, 8'hFF);
        rdc(`OFF_SECOND_DIR, 8'hFE);
        rdc(`OFF_CONV_CONFIG, 8'h7E);
        rdc(`OFF_SECOND_PINS, 8'h80);
        wr(`OFF_THIRD_PINS, 8'hE0);
        cmp_v({5'h0, pu_d, pu_e, pu_j}, 8'h06);
        rdc(`OFF_THIRD_PINS, 8'hC0);
        apb(1'b1, 8'h24, 8'h55, q, e);
        cmp_v({7'h0, e}, 8'h01);
    endtask

    // software frees the port before digital use
    task check_digital();
        wr(`OFF_CMP_CONTROL, 8'h07);
        wr(`OFF_CONV_CONFIG, 8'h00);
        wr(`OFF_SECOND_LATCH, 8'h30);
        wr(`OFF_SECOND_DIR, 8'hCE);
        settle(4);
        cmp_v({sp_oe, 1'b0}, 8'h30);
        cmp_v({sp_out & sp_oe, 1'b0}, 8'h30);
        cmp_v({7'h0, ss_in}, 8'h01);
        rdc(`OFF_SECOND_PINS, 8'hBA);
        rdc(`OFF_SECOND_LATCH, 8'h30);
        wr(`OFF_SECOND_PINS, 8'h10);
        rdc(`OFF_SECOND_LATCH, 8'h10);
    endtask

    task check_masks();
        wr(`OFF_CONV_CONFIG, 8'h7E);
        settle(4);
        rdc(`OFF_SECOND_PINS, 8'h80);
        cmp_v({sp_oe, 1'b0}, 8'h30);
        wr(`OFF_CONV_CONFIG, 8'h00);
        wr(`OFF_CMP_CONTROL, 8'h00);
        settle(4);
        rdc(`OFF_SECOND_PINS, 8'h82);
        // comparator outputs routed onto second pins 1 and 2
        cmp <= 2'h3;
        wr(`OFF_CMP_CONTROL, 8'h08);
        wr(`OFF_SECOND_DIR, 8'hC8);
        settle(4);
        cmp_v({sp_oe, 1'b0}, 8'h36);
        cmp_v({sp_out & sp_oe, 1'b0}, 8'h16);
    endtask

    // memory bus, pwm and capture sharing pins 6 and 7
    task check_first_port();
        cfg <= 4'hD;
        ext <= 4'hE;
        settle(7);
        cmp_v(fp_oe & 8'hC0, 8'hC0);
        cmp_v(fp_out & 8'hC0, 8'h80);
        cmp_v({6'h0, mem_in}, 8'h02);
        cfg <= 4'h5;
        settle(5);
        cmp_v(fp_oe & 8'hC0, 8'h00);
        cmp_v({6'h0, mem_in}, 8'h00);
        cfg <= 4'hD;
        ext <= 4'h0;
        wr(`OFF_FIRST_DIR, 8'h3F);
        pwm_a <= 3'h6;
        pwm_b <= 3'h6;
        settle(5);
        cmp_v(fp_out & fp_oe & 8'hC0, 8'hC0);
        pwm_a <= 3'h7;
        pwm_b <= 3'h7;
        settle(2);
        cmp_v(fp_oe & 8'hC0, 8'h00);
        pwm_a <= 3'h0;
        pwm_b <= 3'h0;
        ccp <= 3'h6;
        settle(2);
        cmp_v(fp_out & fp_oe & 8'h80, 8'h80);
        wr(`OFF_FIRST_DIR, 8'hFF);
        f_lvl <= 8'h80;
        settle(5);
        cmp_v({7'h0, cap_in}, 8'h01);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check_reset();
        check_digital();
        check_masks();
        check_first_port();
        print_verdict();
    end
endmodule // testbench
